// ==== hw/aiw_top.v ====
`timescale 1ns/1ps
`include "aiw_defs.vh"
module aiw_top
#(
	parameter [31:0] INIT_CYCLES = `AIW_INIT_TIME_MS * (`AIW_CLK_HZ / 1000)
)
(
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        wb_cyc,
	input  wire        wb_stb,
	input  wire        wb_we,
	input  wire [7:0]  wb_adr,
	input  wire [3:0]  wb_sel,
	input  wire [31:0] wb_dat_w,
	output reg  [31:0] wb_dat_r,
	output reg         wb_ack,
	input  wire [7:0]  range_switch_bank,
	input  wire [7:0]  filter_switch_bank,
	input  wire        sample_valid,
	input  wire [2:0]  sample_chan,
	input  wire [13:0] sample_count,
	input  wire        diag_mem_ok,
	input  wire        diag_serial_ok,
	input  wire        diag_cal_ok,
	output reg  [7:0]  oor_indicator,
	output reg         data_available,
	output reg         init_busy,
	output reg         hard_fail
);

localparam integer DIAG_FULL   = `AIW_DIAG_PERIOD_US * (`AIW_CLK_HZ / 1000000);
localparam [9:0]   DIAG_CYCLES = DIAG_FULL[9:0];

////////////////////////////////////////////////////////////////
// Functions
function [2:0] aiw_range;
	input [2:0] sw;
	begin
		case (sw)
			3'b111:  aiw_range = `AIW_RNG_1_5V;
			3'b110:  aiw_range = `AIW_RNG_0_10V;
			3'b101:  aiw_range = `AIW_RNG_0_5V;
			3'b100:  aiw_range = `AIW_RNG_BIP_10V;
			3'b011:  aiw_range = `AIW_RNG_BIP_5V;
			default: aiw_range = `AIW_RNG_BAD;
		endcase
	end
endfunction

function [3:0] aiw_shift;
	input [2:0] sw;
	begin
		case (sw)
			3'b111:  aiw_shift = 4'h0;
			3'b110:  aiw_shift = 4'h1;
			3'b101:  aiw_shift = 4'h2;
			3'b100:  aiw_shift = 4'h3;
			3'b011:  aiw_shift = 4'h4;
			3'b010:  aiw_shift = 4'h5;
			3'b001:  aiw_shift = 4'h6;
			default: aiw_shift = 4'h8;
		endcase
	end
endfunction

function [13:0] aiw_conv;
	input [12:0] r;
	input [2:0]  rng;
	reg   [26:0] p;
	reg   [26:0] q;
	reg   [14:0] v;
	begin
		p = 27'h0000000;
		case (rng)
			`AIW_RNG_0_5V:  p = {14'h0000, r} * `AIW_K_5V;
			`AIW_RNG_1_5V:  p = {14'h0000, r} * `AIW_K_4V;
			`AIW_RNG_0_10V: p = {14'h0000, r} * `AIW_K_10V;
			default:        p = 27'h0000000;
		endcase
		q = p + `AIW_ROUND_HALF;
		v = q[26:12];
		if (rng == `AIW_RNG_1_5V)
			v = v + `AIW_CB_ZERO_1_5V;
		if ((rng == `AIW_RNG_0_10V) && (v > `AIW_CB_MAX_10V))
			v = `AIW_CB_MAX_10V;
		aiw_conv = v[13:0];
	end
endfunction

////////////////////////////////////////////////////////////////
// Reset release
reg rst_meta;
reg rst_n;

always @(posedge clk_sys or negedge nrst)
begin
	if (!nrst)
	begin
		rst_meta <= 1'b0;
		rst_n    <= 1'b0;
	end
	else
	begin
		rst_meta <= 1'b1;
		rst_n    <= rst_meta;
	end
end

////////////////////////////////////////////////////////////////
// Switch decode; switches are taken as levels, on reads as one
wire       eight_mode = range_switch_bank[`AIW_SW_COUNT];
wire [2:0] rng_lo     = aiw_range(range_switch_bank[2:0]);
wire [2:0] rng_hi     = aiw_range(range_switch_bank[5:3]);
wire [3:0] sh_lo      = aiw_shift(filter_switch_bank[2:0]);
wire [3:0] sh_hi      = aiw_shift(filter_switch_bank[5:3]);
wire       cb_lo      = !filter_switch_bank[`AIW_SW_FMT_LO];
wire       cb_hi      = !filter_switch_bank[`AIW_SW_FMT_HI];
wire       bip_lo     = (rng_lo == `AIW_RNG_BIP_10V) || (rng_lo == `AIW_RNG_BIP_5V);
wire       bip_hi     = (rng_hi == `AIW_RNG_BIP_10V) || (rng_hi == `AIW_RNG_BIP_5V);
wire       cfg_ok     = range_switch_bank[`AIW_SW_NORMAL]
	&& (rng_lo != `AIW_RNG_BAD) && (rng_hi != `AIW_RNG_BAD)
	&& !sh_lo[3] && !sh_hi[3]
	&& !(cb_lo && bip_lo) && !(cb_hi && bip_hi);

// Any switch change restarts the averaging windows
reg  [15:0] sw_prev;
wire        sw_changed = (sw_prev != {range_switch_bank, filter_switch_bank});

////////////////////////////////////////////////////////////////
// Sample steering and clamping
wire       grp_sel    = eight_mode ? sample_chan[2] : sample_chan[1];
wire       chan_legal = eight_mode || !sample_chan[2];
wire [2:0] grp_shift  = grp_sel ? sh_hi[2:0] : sh_lo[2:0];
wire       under      = sample_count[13];
wire       over       = !under && (sample_count > `AIW_RAW_MAX);
wire [13:0] clamped   = under ? 14'h0000 : (over ? `AIW_RAW_MAX : sample_count);

reg        restart_req;
reg        reinit;
wire       avg_valid;
wire [2:0] avg_chan;
wire [12:0] avg_val;
wire       avg_oor;

aiw_avg u_avg
(
	.clk_sys   (clk_sys),
	.rst_n     (rst_n),
	.clear     (sw_changed || reinit),
	.in_valid  (sample_valid && chan_legal && cfg_ok),
	.in_chan   (sample_chan),
	.in_value  (clamped[12:0]),
	.in_oor    (under || over),
	.in_shift  (grp_shift),
	.out_valid (avg_valid),
	.out_chan  (avg_chan),
	.out_avg   (avg_val),
	.out_oor   (avg_oor)
);

////////////////////////////////////////////////////////////////
// Output words, one per channel, updated on every accepted sample
reg  [15:0] word [0:7];
wire        avg_grp = eight_mode ? avg_chan[2] : avg_chan[1];
wire        avg_cb  = avg_grp ? cb_hi : cb_lo;
wire [2:0]  avg_rng = avg_grp ? rng_hi : rng_lo;
wire [15:0] next_word = avg_cb
	? {avg_oor, 1'b0, aiw_conv(avg_val, avg_rng)}
	: {avg_oor, 1'b0, 1'b0, avg_val};
integer k;

always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		for (k = 0; k < 8; k = k + 1)
			word[k] <= 16'h0000;
		oor_indicator <= 8'h00;
		sw_prev       <= 16'h0000;
	end
	else
	begin
		sw_prev <= {range_switch_bank, filter_switch_bank};
		if (sw_changed || reinit)
		begin
			for (k = 0; k < 8; k = k + 1)
				word[k] <= 16'h0000;
			oor_indicator <= 8'h00;
		end
		else if (avg_valid)
		begin
			word[avg_chan] <= next_word;
			oor_indicator[avg_chan] <= avg_oor;
		end
	end
end

////////////////////////////////////////////////////////////////
// Power-up interval and background diagnostics
localparam [1:0] T_MEM = 2'h0;
localparam [1:0] T_SER = 2'h1;
localparam [1:0] T_CFG = 2'h2;
localparam [1:0] T_CAL = 2'h3;

reg  [31:0] init_cnt;
reg  [9:0]  diag_cnt;
reg         diag_pend;
reg  [1:0]  diag_test;
reg  [1:0]  fail_cnt;
reg  [7:0]  fail_total;
reg  [1:0]  ctrl;
reg         test_ok;

always @*
begin
	case (diag_test)
		T_MEM:   test_ok = diag_mem_ok;
		T_SER:   test_ok = diag_serial_ok;
		T_CFG:   test_ok = cfg_ok;
		T_CAL:   test_ok = diag_cal_ok;
		default: test_ok = 1'b0;
	endcase
end

// Tests wait for a cycle with no conversion so they never stall one
wire diag_tick = (diag_cnt == DIAG_CYCLES - 10'd1);
wire diag_run  = diag_pend && !sample_valid && ctrl[`AIW_CT_DIAG_EN];
wire third     = diag_run && !test_ok && (fail_cnt == 2'h2);

always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		init_cnt   <= 32'h00000000;
		init_busy  <= 1'b1;
		reinit     <= 1'b0;
		diag_cnt   <= 10'h000;
		diag_pend  <= 1'b0;
		diag_test  <= T_MEM;
		fail_cnt   <= 2'h0;
		fail_total <= 8'h00;
		hard_fail  <= 1'b0;
		data_available <= 1'b0;
	end
	else
	begin
		reinit   <= third || restart_req;
		diag_cnt <= diag_tick ? 10'h000 : diag_cnt + 10'h001;
		if (diag_tick)
			diag_pend <= 1'b1;
		else if (diag_run)
			diag_pend <= 1'b0;
		if (diag_run)
		begin
			if (test_ok)
			begin
				fail_cnt  <= 2'h0;
				diag_test <= diag_test + 2'h1;
			end
			else if (third)
			begin
				fail_cnt  <= 2'h0;
				diag_test <= T_MEM;
			end
			else
				fail_cnt <= fail_cnt + 2'h1;
			if (!test_ok && (fail_total != 8'hff))
				fail_total <= fail_total + 8'h01;
		end
		// A third failure or a software restart re-enters power-up
		if (third || restart_req)
		begin
			init_cnt  <= 32'h00000000;
			init_busy <= 1'b1;
		end
		else if (init_busy)
		begin
			if (init_cnt == INIT_CYCLES - 32'h00000001)
				init_busy <= 1'b0;
			init_cnt <= init_cnt + 32'h00000001;
		end
		if (restart_req)
			hard_fail <= 1'b0;
		else if (third)
			hard_fail <= 1'b1;
		data_available <= !init_busy && !hard_fail && !third && !restart_req;
	end
end

////////////////////////////////////////////////////////////////
// Wishbone classic slave, ack one cycle after the request
wire        wb_req  = wb_cyc && wb_stb && !wb_ack;
// Writes land at the edge that sees ack high, as the master does
wire        wr_ctrl = wb_cyc && wb_stb && wb_ack && wb_we && wb_sel[0] && (wb_adr == `AIW_OFF_CTRL);
wire [31:0] status  = {16'h0000, oor_indicator, 4'h0, cfg_ok, hard_fail, init_busy, data_available};
reg  [31:0] rd_mux;

always @*
begin
	rd_mux = 32'h00000000;
	if (wb_adr[7:5] == 3'h0)
		rd_mux = data_available ? {16'h0000, word[wb_adr[4:2]]} : 32'h00000000;
	else
	begin
		case (wb_adr)
			`AIW_OFF_STATUS: rd_mux = status;
			`AIW_OFF_CTRL:   rd_mux = {30'h00000000, ctrl};
			`AIW_OFF_DIAG:   rd_mux = {20'h00000, fail_total, diag_test, fail_cnt};
			default:         rd_mux = 32'h00000000;
		endcase
	end
end

always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		wb_ack      <= 1'b0;
		wb_dat_r    <= 32'h00000000;
		ctrl        <= `AIW_CTRL_RESET;
		restart_req <= 1'b0;
	end
	else
	begin
		wb_ack      <= wb_req;
		restart_req <= wr_ctrl && wb_dat_w[`AIW_CT_RESTART];
		if (wb_req && !wb_we)
			wb_dat_r <= rd_mux;
		if (wr_ctrl)
			ctrl <= {wb_dat_w[`AIW_CT_DIAG_EN], 1'b0};
	end
end

endmodule // aiw_top

// ==== hw/aiw_defs.vh ====
`ifndef AIW_DEFS_VH
`define AIW_DEFS_VH

// Clock and timing
`define AIW_CLK_HZ          100000000
`define AIW_INIT_TIME_MS    5000
`define AIW_DIAG_PERIOD_US  10

// Count limits
`define AIW_RAW_MAX         14'd4200
`define AIW_RAW_FULL_SCALE  14'd4096
`define AIW_RAW_BIP_ZERO    14'd2048
`define AIW_CB_ZERO_1_5V    15'd1000
`define AIW_CB_MAX_10V      15'd9999
`define AIW_K_5V            27'd5000
`define AIW_K_4V            27'd4000
`define AIW_K_10V           27'd10000
`define AIW_ROUND_HALF      27'd2048

// Range codes
`define AIW_RNG_1_5V        3'h0
`define AIW_RNG_0_10V       3'h1
`define AIW_RNG_0_5V        3'h2
`define AIW_RNG_BIP_10V     3'h3
`define AIW_RNG_BIP_5V      3'h4
`define AIW_RNG_BAD         3'h7

// Switch positions (index 0 is switch 1)
`define AIW_SW_COUNT        6
`define AIW_SW_NORMAL       7
`define AIW_SW_FMT_LO       6
`define AIW_SW_FMT_HI       7

// Output word fields
`define AIW_W_OOR           15
`define AIW_W_SPARE         14

// Register byte offsets
`define AIW_OFF_CH0         8'h00
`define AIW_OFF_STATUS      8'h20
`define AIW_OFF_CTRL        8'h24
`define AIW_OFF_DIAG        8'h28

// Status and control bits
`define AIW_ST_AVAIL        0
`define AIW_ST_INIT         1
`define AIW_ST_HARD         2
`define AIW_ST_CFG_OK       3
`define AIW_CT_RESTART      0
`define AIW_CT_DIAG_EN      1
`define AIW_CTRL_RESET      2'h2

`endif

// ==== hw/aiw_avg.v ====
`timescale 1ns/1ps
module aiw_avg
(
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        clear,
	input  wire        in_valid,
	input  wire [2:0]  in_chan,
	input  wire [12:0] in_value,
	input  wire        in_oor,
	input  wire [2:0]  in_shift,
	output reg         out_valid,
	output reg  [2:0]  out_chan,
	output reg  [12:0] out_avg,
	output reg         out_oor
);

////////////////////////////////////////////////////////////////
// History of 64 entries per channel: value plus its flag
reg  [13:0] hist    [0:511];
reg  [5:0]  wr_ptr  [0:7];
reg  [6:0]  fill    [0:7];
reg  [18:0] sum     [0:7];
reg  [6:0]  oor_cnt [0:7];

wire [6:0]  win     = 7'd1 << in_shift;
wire [5:0]  old_idx = wr_ptr[in_chan] - win[5:0];
wire        full    = (fill[in_chan] >= win);
wire [13:0] old_ent = full ? hist[{in_chan, old_idx}] : 14'h0000;
wire [18:0] next_sum = sum[in_chan] - {6'h00, old_ent[12:0]} + {6'h00, in_value};
wire [6:0]  next_oor = oor_cnt[in_chan] - {6'h00, old_ent[13]} + {6'h00, in_oor};
wire [18:0] quot     = next_sum >> in_shift;

integer i;

always @(posedge clk_sys)
begin
	if (in_valid)
		hist[{in_chan, wr_ptr[in_chan]}] <= {in_oor, in_value};
end

// Window primes with zeros after a clear: no extra latency, short settle
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			wr_ptr[i]  <= 6'h00;
			fill[i]    <= 7'h00;
			sum[i]     <= 19'h00000;
			oor_cnt[i] <= 7'h00;
		end
		out_valid <= 1'b0;
		out_chan  <= 3'h0;
		out_avg   <= 13'h0000;
		out_oor   <= 1'b0;
	end
	else if (clear)
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			wr_ptr[i]  <= 6'h00;
			fill[i]    <= 7'h00;
			sum[i]     <= 19'h00000;
			oor_cnt[i] <= 7'h00;
		end
		out_valid <= 1'b0;
	end
	else
	begin
		out_valid <= in_valid;
		if (in_valid)
		begin
			wr_ptr[in_chan]  <= wr_ptr[in_chan] + 6'h01;
			if (!full)
				fill[in_chan] <= fill[in_chan] + 7'h01;
			sum[in_chan]     <= next_sum;
			oor_cnt[in_chan] <= next_oor;
			out_chan <= in_chan;
			out_avg  <= quot[12:0];
			out_oor  <= (next_oor != 7'h00);
		end
	end
end

endmodule // aiw_avg

// ==== sim/aiw_chk.sv ====
`timescale 1ns/1ps
module aiw_chk
#(
	parameter [31:0] INIT_CYCLES = 32'd200
)
(
	input logic        clk_sys,
	input logic        nrst,
	input logic        wb_cyc,
	input logic        wb_stb,
	input logic        wb_we,
	input logic [7:0]  wb_adr,
	input logic [31:0] wb_dat_r,
	input logic        wb_ack,
	input logic [7:0]  range_switch_bank,
	input logic        sample_valid,
	input logic [2:0]  sample_chan,
	input logic [13:0] sample_count,
	input logic [7:0]  oor_indicator,
	input logic        data_available,
	input logic        init_busy,
	input logic        hard_fail
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	// Length of each power-up interval
	logic [31:0] busy_cnt;
	always @(posedge clk_sys or negedge nrst)
		if (!nrst)
			busy_cnt <= 32'h0;
		else if (init_busy)
			busy_cnt <= busy_cnt + 32'h1;
		else
			busy_cnt <= 32'h0;
	////////////////////////////////////////////////////////////////
	ack_pulse_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
		else $error("bus answer not a single cycle pulse");
	init_gate_a: assert property (init_busy |-> !data_available)
		else $error("data offered during power-up");
	init_len_a: assert property ($fell(init_busy) |-> busy_cnt >= INIT_CYCLES)
		else $error("power-up interval too short");
	fail_gate_a: assert property (hard_fail |-> !data_available)
		else $error("data offered after hard failure");
	fail_clear_a: assert property ($rose(hard_fail) |-> ##[0:2] (!data_available && oor_indicator == 8'h00))
		else $error("hard failure did not reset the block");
	read_gate_a: assert property (wb_ack && !wb_we && wb_adr < 8'h20 && !data_available
		&& !$past(data_available) |-> wb_dat_r == 32'h0)
		else $error("channel word readable while withheld");
	word_bits_a: assert property (wb_ack && !wb_we && wb_adr < 8'h20 |-> !wb_dat_r[14] && wb_dat_r[31:16] == 16'h0)
		else $error("spare status bit or upper bits set");
	oor_match_a: assert property (wb_ack && !wb_we && wb_adr < 8'h20 && data_available
		&& $past(data_available) && $stable(oor_indicator) |-> wb_dat_r[15] == oor_indicator[wb_adr[4:2]])
		else $error("word flag disagrees with indicator");
	oor_flag_a: assert property (sample_valid && data_available && !hard_fail && range_switch_bank[7]
		&& (range_switch_bank[6] || !sample_chan[2]) && sample_count > 14'd4200
		|=> ##1 oor_indicator[$past(sample_chan, 2)])
		else $error("out of range sample not flagged");
endmodule // aiw_chk

bind aiw_top aiw_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk_sys, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
	.wb_dat_r, .wb_ack, .range_switch_bank, .sample_valid, .sample_chan, .sample_count, .oor_indicator,
	.data_available, .init_busy, .hard_fail);

// ==== sim/aiw_plc.sv ====
`timescale 1ns/1ps
module aiw_plc
(
	input  logic        clk_sys,
	input  logic        wb_ack,
	input  logic [31:0] wb_dat_r,
	output logic        wb_cyc,
	output logic        wb_stb,
	output logic        wb_we,
	output logic [7:0]  wb_adr,
	output logic [3:0]  wb_sel,
	output logic [31:0] wb_dat_w,
	output logic        done,
	output logic [31:0] rd_data,
	output logic        late
);
	initial
	begin
		{wb_cyc, wb_stb, wb_we, done, late} = 5'h0;
		{wb_adr, wb_sel, wb_dat_w, rd_data} = 76'h0;
	end
	////////////////////////////////////////////////////////////////
	// Classic cycle; request held until ack, no fixed latency assumed
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat_w <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		late <= (n >= 50);
		rd_data <= wb_dat_r;
		done <= 1'b1;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		// Released data must not keep looking valid
		wb_dat_w <= ~d;
		@(posedge clk_sys);
		done <= 1'b0;
	endtask
endmodule // aiw_plc

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, nrst, wb_cyc, wb_stb, wb_we, wb_ack, done, late;
	logic [7:0]  wb_adr, range_switch_bank, filter_switch_bank, oor_indicator, wr_ch;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd_data;
	logic        sample_valid, diag_mem_ok, diag_serial_ok, diag_cal_ok, data_available, init_busy, hard_fail;
	logic [2:0]  sample_chan;
	logic [13:0] sample_count;
	logic [63:0] q[$];
	logic        wfl[8][$];
	int          win[8][$];
	int          num_errors, checks_done, seed, r, c;
	int          bnd[5] = '{0, 4096, 4200, 4201, -1};

	aiw_top #(.INIT_CYCLES(32'd200)) DUT (.clk_sys, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
		.wb_dat_r, .wb_ack, .range_switch_bank, .filter_switch_bank, .sample_valid, .sample_chan, .sample_count,
		.diag_mem_ok, .diag_serial_ok, .diag_cal_ok, .oor_indicator, .data_available, .init_busy, .hard_fail);
	aiw_plc u_plc (.clk_sys, .wb_ack, .wb_dat_r, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .done,
		.rd_data, .late);

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	// Reference model of the averaging windows
	function automatic int grp(input int ch);
		return range_switch_bank[6] ? ch / 4 : (ch / 2) % 2;
	endfunction
	function automatic int shn(input int ch);
		return 7 - filter_switch_bank[3*grp(ch)+:3];
	endfunction
	function automatic bit cfg_ok();
		for (int g = 0; g < 2; g++)
			if (range_switch_bank[3*g+:3] < 3'b011 || filter_switch_bank[3*g+:3] == 3'b000
				|| (!filter_switch_bank[6+g] && range_switch_bank[3*g+:3] < 3'b101))
				return 0;
		return range_switch_bank[7];
	endfunction
	function automatic void clr();
		for (int ch = 0; ch < 8; ch++)
		begin
			win[ch] = {};
			wfl[ch] = {};
			wr_ch[ch] = 1'b0;
			repeat (1 << shn(ch))
			begin
				win[ch].push_back(0);
				wfl[ch].push_back(1'b0);
			end
		end
	endfunction
	function automatic void put(input int ch, input int v);
		if (!cfg_ok() || (!range_switch_bank[6] && ch > 3))
			return;
		win[ch].push_back(v < 0 ? 0 : (v > 4200 ? 4200 : v));
		wfl[ch].push_back(v < 0 || v > 4200);
		void'(win[ch].pop_front());
		void'(wfl[ch].pop_front());
		wr_ch[ch] = 1'b1;
	endfunction
	function automatic logic [31:0] word(input int ch);
		int s, a, g, cb;
		logic f;
		logic [2:0] rc;
		s = 0;
		f = 1'b0;
		if (!wr_ch[ch])
			return 32'h0;
		foreach (win[ch][i])
		begin
			s += win[ch][i];
			f |= wfl[ch][i];
		end
		g = grp(ch);
		a = s >> shn(ch);
		rc = range_switch_bank[3*g+:3];
		if (filter_switch_bank[6+g])
			return {16'h0, f, 2'b00, a[12:0]};
		cb = rc == 3'b111 ? (a * 4000 + 2048) / 4096 + 1000 : (a * (rc == 3'b101 ? 5000 : 10000) + 2048) / 4096;
		if (cb > 9999)
			cb = 9999;
		return {16'h0, f, 1'b0, cb[13:0]};
	endfunction
	function automatic logic [31:0] stat();
		logic [7:0] o;
		logic [31:0] w;
		for (int ch = 0; ch < 8; ch++)
		begin
			w = word(ch);
			o[ch] = w[15];
		end
		return {16'h0, o, 8'h09};
	endfunction
	////////////////////////////////////////////////////////////////
	// Drivers note expectations; the monitor below settles them
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q.push_back({m, e});
		u_plc.acc(1'b0, a, 32'h0);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		q.push_back(64'h0);
		u_plc.acc(1'b1, a, d);
	endtask
	task smp(input int ch, input int v);
		@(posedge clk_sys);
		sample_valid <= 1'b1;
		sample_chan <= ch[2:0];
		sample_count <= v[13:0];
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		put(ch, v);
		repeat (2) @(posedge clk_sys);
		rd({ch[5:0], 2'b00}, word(ch), 32'hffffffff);
	endtask
	task cmp(input logic [63:0] e);
		checks_done++;
		if (late !== 1'b0 || (rd_data & e[63:32]) !== e[31:0])
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e[31:0], rd_data & e[63:32]);
		end
		// A bus access that never got its answer ends the run
		if (late !== 1'b0)
			results();
	endtask
	always @(posedge clk_sys)
		if (done)
			cmp(q.pop_front());
	// Bounded wait on a status port; a hang ends the run
	task wt(input bit hf);
		int n;
		n = 0;
		while ((hf ? hard_fail : data_available) !== 1'b1 && n < 20000)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20000)
		begin
			num_errors++;
			results();
		end
	endtask
	task results();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		results();
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		{nrst, sample_valid, sample_chan, sample_count} = 19'h0;
		{diag_mem_ok, diag_serial_ok, diag_cal_ok} = 3'h7;
		range_switch_bank = 8'hfd;
		filter_switch_bank = 8'h2f;
		{num_errors, checks_done, seed} = {32'd0, 32'd0, 32'd82};
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		clr();
		rd(8'h00, 32'h0, 32'hffffffff);
		rd(8'h20, 32'h2, 32'h7);
		rd(8'h24, 32'h2, 32'hffffffff);
		wt(1'b0);
		rd(8'h20, stat(), 32'hffffffff);
		rd(8'h3c, 32'h0, 32'hffffffff);
		foreach (bnd[i])
			smp(0, bnd[i]);
		for (int i = 0; i < 5; i++)
			smp(5, i == 0 ? 4201 : 100);
		repeat (16)
		begin
			r = $random(seed);
			c = $random(seed) % 4400;
			smp(r & 7, c);
		end
		rd(8'h20, stat(), 32'hffffffff);
		// Four channels, both groups converted
		range_switch_bank <= 8'hbd;
		filter_switch_bank <= 8'h2e;
		repeat (5) @(posedge clk_sys);
		clr();
		for (int ch = 0; ch < 6; ch++)
			smp(ch % 5, ch == 3 ? -5 : 4096);
		smp(1, 4096);
		// Converted output on a bipolar group is refused
		range_switch_bank <= 8'h9d;
		repeat (5) @(posedge clk_sys);
		clr();
		smp(2, 1000);
		// Raw format on both groups; bipolar group is legal in raw
		filter_switch_bank <= 8'hef;
		repeat (5) @(posedge clk_sys);
		clr();
		smp(2, 1000);
		smp(0, 4201);
		range_switch_bank <= 8'hfd;
		filter_switch_bank <= 8'h2f;
		diag_mem_ok <= 1'b0;
		wt(1'b1);
		// Third failure re-enters the power-up interval as well
		rd(8'h20, 32'h6, 32'h7);
		rd(8'h00, 32'h0, 32'hffffffff);
		diag_mem_ok <= 1'b1;
		wr(8'h24, 32'h3);
		rd(8'h24, 32'h2, 32'hffffffff);
		wt(1'b0);
		clr();
		smp(6, 4300);
		rd(8'h20, stat(), 32'hffffffff);
		repeat (5) @(posedge clk_sys);
		results();
	end
endmodule // testbench
